// >>> logic/pgp_pkg.sv
`default_nettype none
package pgp_pkg;
	// Byte offsets on the register bus
	localparam logic [4:0] OFF_CMD = 5'h00;
	localparam logic [4:0] OFF_DATA = 5'h04;
	localparam logic [4:0] OFF_RESP = 5'h08;
	localparam logic [4:0] OFF_RDATA = 5'h0C;
	localparam logic [4:0] OFF_STATUS = 5'h10;
	localparam logic [4:0] OFF_MASK = 5'h14;
	localparam logic [4:0] OFF_DRIVE = 5'h18;

	// Interface byte codes, returned status flags and the length byte value
	localparam logic [7:0] INTF_GPIO = 8'h08;
	localparam logic [7:0] INTF_WRITE_FLAG = 8'h10;
	localparam logic [7:0] SPI_WIDE_ADDRESS_MODE = 8'h04;
	localparam logic [7:0] FLAG_DONE = 8'h20;
	localparam logic [7:0] BUS_FAILURE_FLAG = 8'h40;
	localparam logic [7:0] FLAG_REQ_ERROR = 8'h80;
	localparam logic [7:0] IO_LENGTH = 8'h01;

	// Pin positions inside the pin byte; bit 7 has no pin
	localparam int PIN_COUNT = 7;
	localparam int PORT3_PIN5_LINE_BIT = 6;
	localparam int PORT3_PIN4_LINE_BIT = 5;
	localparam int PORT3_PIN3_LINE_BIT = 4;
	localparam int PORT1_PIN3_LINE_BIT = 3;
	localparam int PORT1_PIN2_LINE_BIT = 2;
	localparam int PORT1_PIN1_LINE_BIT = 1;
	localparam int PORT1_PIN0_LINE_BIT = 0;

	// Status register layout (bits 2..0 are also the mask layout; the busy bit is status only)
	localparam int STATUS_W = 3;
	localparam int ST_DONE_BIT = 0;
	localparam int ST_FAIL_BIT = 1;
	localparam int ST_REQERR_BIT = 2;
	localparam int ST_BUSY_BIT = 8;

	// Reset values
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [2:0] RST_STATUS = 3'h0;
	localparam logic [6:0] RST_PINS = 7'h00;

	// Pin settle time: output flop, pad and two synchroniser stages
	localparam int CLK_PERIOD_NS = 25;
	localparam int SETTLE_NS = 75;
	localparam logic [1:0] SETTLE_CYC = 2'((SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	typedef struct packed {
		logic [7:0] regaddr;
		logic [7:0] length;
		logic [7:0] slave;
		logic [7:0] intf;
	} pgp_hdr_t;

	typedef enum logic [2:0] {
		PGP_IDLE = 3'b001,
		PGP_SETTLE = 3'b010,
		PGP_FINISH = 3'b100
	} pgp_state_t;
endpackage
`default_nettype wire

// >>> logic/pgp_port.sv
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - Seven pins exist and an interface code of 0x08 addresses them instead of a serial bus.
// - The pin byte holds the three port-three pins in bits 6..4 and the four port-one pins in 3..0, bit 7 unused.
// - A packet with interface byte 0x18 drives each pin to its bit in data byte four.
// - Length is 0x01 and the slave and register bytes are ignored by the device.
// - A read packet 0x08 samples the pins and returns 0x28 with the header echoed and the pins in byte four.
// - A clean request returns byte zero as the interface byte ORed with 0x20.
// - A failed interface returns byte zero with 0x40 set instead of the done flag.
module pgp_port (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	// Avalon-MM slave
	input wire logic [4:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// Interrupt
	output logic irq_o,
	// Pins
	input wire logic [6:0] gpio_line_i,
	output logic [6:0] gpio_line_o,
	output logic [6:0] gpio_line_oe_o
);
	// Bus handshake
	logic waitreq_r;
	logic waitreq_nxt;
	logic [31:0] readdata_r;
	logic [31:0] readdata_nxt;
	logic commit;
	logic [31:0] rword;
	logic [31:0] wmerged;
	// Software registers
	pgp_pkg::pgp_hdr_t cmd_r;
	pgp_pkg::pgp_hdr_t cmd_nxt;
	logic [7:0] data_r;
	logic [7:0] data_nxt;
	logic [2:0] mask_r;
	logic [2:0] mask_nxt;
	logic go;
	logic [2:0] clr_v;
	// Packet sequencer
	pgp_pkg::pgp_state_t state_r;
	pgp_pkg::pgp_state_t state_nxt;
	logic [1:0] cnt_r;
	logic [1:0] cnt_nxt;
	logic busy;
	// Response
	pgp_pkg::pgp_hdr_t resp_r;
	pgp_pkg::pgp_hdr_t resp_nxt;
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;
	logic is_write;
	logic valid;
	logic [2:0] set_v;
	// Status and interrupt
	logic [2:0] status_r;
	logic [2:0] status_nxt;
	logic irq_r;
	logic irq_nxt;
	// Pins
	logic [6:0] drive_r;
	logic [6:0] drive_nxt;
	logic [6:0] pin_out_r;
	logic [6:0] pin_out_nxt;
	logic [6:0] sync1_r;
	logic [6:0] sync2_r;

	function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] be);
		logic [31:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				res[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return res;
	endfunction

	// Register read mux; busy reads back in status bit 8
	always_comb begin
		busy = (state_r != pgp_pkg::PGP_IDLE);
		rword = 32'h0000_0000;
		case (avs_address_i)
			pgp_pkg::OFF_CMD: rword = cmd_r;
			pgp_pkg::OFF_DATA: rword = {24'h00_0000, data_r};
			pgp_pkg::OFF_RESP: rword = resp_r;
			pgp_pkg::OFF_RDATA: rword = {24'h00_0000, rdata_r};
			pgp_pkg::OFF_STATUS: begin
				rword[pgp_pkg::STATUS_W-1:0] = status_r;
				rword[pgp_pkg::ST_BUSY_BIT] = busy;
			end
			pgp_pkg::OFF_MASK: rword = {29'h0000_0000, mask_r};
			pgp_pkg::OFF_DRIVE: rword = {25'h000_0000, drive_r};
			default: rword = 32'h0000_0000;
		endcase
	end

	// Bus handshake: one wait cycle, then waitrequest low for exactly one cycle
	always_comb begin
		commit = 1'b0;
		waitreq_nxt = waitreq_r;
		readdata_nxt = readdata_r;
		// A command write is held off while a packet is in flight
		if (!waitreq_r) begin
			waitreq_nxt = 1'b1;
			commit = avs_write_i;
		end else if ((avs_read_i || avs_write_i) &&
			!(avs_write_i && avs_address_i == pgp_pkg::OFF_CMD && busy)) begin
			waitreq_nxt = 1'b0;
			// Loaded with the accept so the data stands while waitrequest is low
			readdata_nxt = avs_read_i ? rword : 32'h0000_0000;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			waitreq_r <= 1'b1;
			readdata_r <= pgp_pkg::RST_WORD;
		end else begin
			waitreq_r <= waitreq_nxt;
			readdata_r <= readdata_nxt;
		end
	end

	// Register writes take effect on the edge that ends the accept cycle
	always_comb begin
		go = 1'b0;
		clr_v = 3'h0;
		cmd_nxt = cmd_r;
		data_nxt = data_r;
		mask_nxt = mask_r;
		wmerged = be_merge(rword, avs_writedata_i, avs_byteenable_i);
		if (commit) begin
			case (avs_address_i)
				pgp_pkg::OFF_CMD: begin
					cmd_nxt = wmerged;
					go = 1'b1;
				end
				pgp_pkg::OFF_DATA: data_nxt = wmerged[7:0];
				pgp_pkg::OFF_STATUS: clr_v = wmerged[pgp_pkg::STATUS_W-1:0];
				pgp_pkg::OFF_MASK: mask_nxt = wmerged[pgp_pkg::STATUS_W-1:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cmd_r <= pgp_pkg::RST_WORD;
			data_r <= pgp_pkg::RST_BYTE;
			mask_r <= pgp_pkg::RST_STATUS;
		end else begin
			cmd_r <= cmd_nxt;
			data_r <= data_nxt;
			mask_r <= mask_nxt;
		end
	end

	// Packet sequencer; the settle count covers the pad and both synchroniser stages
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		case (state_r)
			pgp_pkg::PGP_IDLE: begin
				if (go) begin
					state_nxt = pgp_pkg::PGP_SETTLE;
					cnt_nxt = pgp_pkg::SETTLE_CYC - 2'd1;
				end
			end
			pgp_pkg::PGP_SETTLE: begin
				if (cnt_r == 2'd0) begin
					state_nxt = pgp_pkg::PGP_FINISH;
				end else begin
					cnt_nxt = cnt_r - 2'd1;
				end
			end
			pgp_pkg::PGP_FINISH: state_nxt = pgp_pkg::PGP_IDLE;
			default: state_nxt = pgp_pkg::PGP_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_r <= pgp_pkg::PGP_IDLE;
			cnt_r <= 2'd0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// Pin outputs; the enables may also be set by software through DRIVE
	always_comb begin
		drive_nxt = drive_r;
		pin_out_nxt = pin_out_r;
		if (commit && avs_address_i == pgp_pkg::OFF_DRIVE) begin
			drive_nxt = wmerged[6:0];
		end
		// Slave and register bytes play no part in the decision
		if (state_r == pgp_pkg::PGP_IDLE && go &&
			cmd_nxt.intf == (pgp_pkg::INTF_GPIO | pgp_pkg::INTF_WRITE_FLAG)) begin
			pin_out_nxt = data_r[6:0];
			drive_nxt = {pgp_pkg::PIN_COUNT{1'b1}};
		end
	end

	// Response and events, decided once the pins have settled
	always_comb begin
		logic [7:0] flag;
		flag = 8'h00;
		set_v = 3'h0;
		resp_nxt = resp_r;
		rdata_nxt = rdata_r;
		is_write = (cmd_r.intf == (pgp_pkg::INTF_GPIO | pgp_pkg::INTF_WRITE_FLAG));
		// Only the two pin codes are served; serial codes have no engine here
		valid = is_write || (cmd_r.intf == pgp_pkg::INTF_GPIO);
		if (state_r == pgp_pkg::PGP_FINISH) begin
			if (!valid) begin
				flag = pgp_pkg::FLAG_REQ_ERROR;
				set_v[pgp_pkg::ST_REQERR_BIT] = 1'b1;
				rdata_nxt = data_r;
			end else if (is_write && |((sync2_r ^ pin_out_r) & drive_r)) begin
				// A driven pin that reads back wrong is held by something else
				flag = pgp_pkg::BUS_FAILURE_FLAG;
				set_v[pgp_pkg::ST_FAIL_BIT] = 1'b1;
				rdata_nxt = {1'b0, pin_out_r};
			end else begin
				flag = pgp_pkg::FLAG_DONE;
				set_v[pgp_pkg::ST_DONE_BIT] = 1'b1;
				rdata_nxt = {1'b0, is_write ? pin_out_r : sync2_r};
			end
			resp_nxt = cmd_r;
			resp_nxt.intf = cmd_r.intf | flag;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			resp_r <= pgp_pkg::RST_WORD;
			rdata_r <= pgp_pkg::RST_BYTE;
		end else begin
			resp_r <= resp_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// A new event wins over a clear in the same cycle
	always_comb begin
		status_nxt = (status_r & ~clr_v) | set_v;
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			status_r <= pgp_pkg::RST_STATUS;
		end else begin
			status_r <= status_nxt;
		end
	end

	// Built from the next status so the interrupt rises with the event
	always_comb begin
		irq_nxt = |(status_nxt & mask_nxt);
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= irq_nxt;
		end
	end

	// Per pin: output flop, enable flop and a two-stage synchroniser
	for (genvar g = 0; g < pgp_pkg::PIN_COUNT; g++) begin : g_pin
		always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
			if (!rst_b_i) begin
				pin_out_r[g] <= pgp_pkg::RST_PINS[g];
				drive_r[g] <= pgp_pkg::RST_PINS[g];
				sync1_r[g] <= pgp_pkg::RST_PINS[g];
				sync2_r[g] <= pgp_pkg::RST_PINS[g];
			end else begin
				pin_out_r[g] <= pin_out_nxt[g];
				drive_r[g] <= drive_nxt[g];
				sync1_r[g] <= gpio_line_i[g];
				sync2_r[g] <= sync1_r[g];
			end
		end
	end

	assign avs_readdata_o = readdata_r;
	assign avs_waitrequest_o = waitreq_r;
	assign irq_o = irq_r;
	assign gpio_line_o = pin_out_r;
	assign gpio_line_oe_o = drive_r;
endmodule
`default_nettype wire

// >>> verification/pgp_pins_model.sv
`timescale 1ns/10ps
`default_nettype none
module pgp_pins_model (
	// Clock
	input wire logic sys_clk_i,
	// Device side of the pins
	input wire logic [6:0] drive_i,
	input wire logic [6:0] drive_oe_i,
	// Fault injection from the bench
	input wire logic [6:0] flip_i,
	output logic [6:0] level_o
);
	logic [6:0] noise_r = 7'h2A;
	// Undriven pins float, showing a pattern that inverts on every clock
	always @(posedge sys_clk_i) noise_r <= ~noise_r;
	assign level_o = ((drive_i & drive_oe_i) | (noise_r & ~drive_oe_i)) ^ flip_i;
endmodule
`default_nettype wire

// >>> verification/pgp_port_checker.sv
`timescale 1ns/10ps
`default_nettype none
module pgp_port_checker (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	// Bus and pins
	input wire logic [4:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic avs_waitrequest_o,
	input wire logic [6:0] gpio_line_o,
	input wire logic [6:0] gpio_line_oe_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_b_i);
	logic cmd_w, rsp, drv;
	logic [6:0] dat_r, dat_nxt;
	logic [31:0] cmd_r, cmd_nxt;
	logic [2:0] age_r, age_nxt;
	assign cmd_w = !avs_waitrequest_o && avs_write_i && avs_address_i == pgp_pkg::OFF_CMD;
	assign drv = cmd_w && avs_writedata_i[7:0] == 8'h18;
	// Readdata is loaded one edge before acceptance, so allow a spare cycle
	assign rsp = !avs_waitrequest_o && avs_read_i && avs_address_i == pgp_pkg::OFF_RESP
		&& age_r >= 3'h5;
	always_comb begin
		dat_nxt = dat_r;
		if (!avs_waitrequest_o && avs_write_i && avs_address_i == pgp_pkg::OFF_DATA) begin
			dat_nxt = avs_writedata_i[6:0];
		end
		cmd_nxt = cmd_w ? avs_writedata_i : cmd_r;
		age_nxt = cmd_w ? 3'h0 : age_r + 3'(age_r != 3'h7);
	end
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			dat_r <= 7'h00;
			cmd_r <= 32'h0;
			age_r <= 3'h0;
		end else begin
			dat_r <= dat_nxt;
			cmd_r <= cmd_nxt;
			age_r <= age_nxt;
		end
	end
	chk_pins_drive: assert property (drv |=> gpio_line_o == dat_r)
		else $error("pins differ from data byte");
	chk_all_enabled: assert property (drv |=> gpio_line_oe_o == 7'h7F)
		else $error("not all seven pins driven");
	chk_top_pin: assert property (drv |=> gpio_line_o[pgp_pkg::PORT3_PIN5_LINE_BIT] == dat_r[6])
		else $error("bit six pin wrong");
	chk_pins_hold: assert property (!$past(cmd_w) |-> $stable(gpio_line_o))
		else $error("pins moved without a packet");
	chk_bit7_low: assert property (!avs_waitrequest_o && avs_read_i && avs_address_i ==
		pgp_pkg::OFF_RDATA && (cmd_r[7:0] & 8'hEF) == 8'h08 |-> !avs_readdata_o[7])
		else $error("pin byte bit seven set");
	chk_hdr_echo: assert property (rsp |-> avs_readdata_o[31:8] == cmd_r[31:8])
		else $error("header not echoed");
	chk_read_code: assert property (rsp && cmd_r[7:0] == 8'h08 |-> avs_readdata_o[7:0] == 8'h28)
		else $error("read code wrong");
	chk_write_code: assert property (rsp && cmd_r[7:0] == 8'h18 |->
		avs_readdata_o[7:0] == 8'h38 || avs_readdata_o[7:0] == 8'h58)
		else $error("write code wrong");
endmodule
bind pgp_port pgp_port_checker i_chk (.sys_clk_i, .rst_b_i, .avs_address_i, .avs_read_i,
	.avs_write_i, .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .gpio_line_o,
	.gpio_line_oe_o);
`default_nettype wire

// >>> verification/pgp_port_tb.sv
`timescale 1ns/10ps
`default_nettype none
module pgp_port_tb;
	logic clk = 0;
	logic rst_b = 0;
	logic [4:0] adr = 0;
	logic rd = 0;
	logic wr = 0;
	logic [31:0] wd = 0;
	logic [31:0] rdata, h, r;
	logic wait_o, irq;
	logic [6:0] po, poe, pi;
	logic [6:0] flip = 0;
	logic [31:0] q[$];
	int fail_count = 0;
	int comparisons = 0;
	int seed = 75;
	initial forever #12.5 clk = ~clk;
	pgp_port i_dut (.sys_clk_i(clk), .rst_b_i(rst_b), .avs_address_i(adr), .avs_read_i(rd),
		.avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hF), .avs_readdata_o(rdata),
		.avs_waitrequest_o(wait_o), .irq_o(irq), .gpio_line_i(pi), .gpio_line_o(po),
		.gpio_line_oe_o(poe));
	pgp_pins_model i_pins (.sys_clk_i(clk), .drive_i(po), .drive_oe_i(poe), .flip_i(flip),
		.level_o(pi));
	task automatic print_verdict;
		if (fail_count == 0 && comparisons > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		int n;
		n = 0;
		adr <= a;
		wr <= w;
		rd <= !w;
		wd <= d;
		do begin
			@(posedge clk);
			n++;
		end while (wait_o !== 1'b0 && n < 50);
		if (wait_o !== 1'b0) begin
			fail_count++;
			print_verdict();
		end
		rd <= 0;
		wr <= 0;
		@(posedge clk);
	endtask
	task automatic rd_chk(input logic [4:0] a, input logic [31:0] e);
		q.push_back(e);
		bus(0, a, 32'h0);
	endtask
	// Ignored header bytes are random so the echo is really exercised
	task automatic pkt(input logic [7:0] intf, b4, rs, rb, input logic [31:0] st);
		h = $random(seed);
		h[23:16] = pgp_pkg::IO_LENGTH;
		h[7:0] = intf;
		bus(1, pgp_pkg::OFF_DATA, {24'h0, b4});
		bus(1, pgp_pkg::OFF_CMD, h);
		repeat (6) @(posedge clk);
		cmp({31'h0, |st[1:0]}, {31'h0, irq});
		rd_chk(pgp_pkg::OFF_RESP, {h[31:8], rs});
		rd_chk(pgp_pkg::OFF_RDATA, {24'h0, rb});
		rd_chk(pgp_pkg::OFF_STATUS, st);
		bus(1, pgp_pkg::OFF_STATUS, 32'h7);
	endtask
	always @(posedge clk) begin
		if (rd && wait_o === 1'b0 && q.size() > 0) cmp(q.pop_front(), rdata);
	end
	initial begin
		repeat (3) @(posedge clk);
		rst_b <= 1;
		@(posedge clk);
		bus(1, pgp_pkg::OFF_MASK, 32'h3);
		for (int i = 0; i < 3; i++) begin
			r = $random(seed);
			pkt(8'h18, r[7:0], 8'h38, {1'b0, r[6:0]}, 32'h1);
			pkt(8'h08, r[7:0], 8'h28, {1'b0, r[6:0]}, 32'h1);
		end
		rd_chk(pgp_pkg::OFF_MASK, 32'h3);
		rd_chk(pgp_pkg::OFF_DRIVE, 32'h7F);
		flip <= 7'h10;
		pkt(8'h18, r[7:0], 8'h58, {1'b0, r[6:0]}, 32'h2);
		flip <= 7'h00;
		// Serial code: masked-out error bit must keep the interrupt low
		pkt(8'h04, 8'h5A, 8'h84, 8'h5A, 32'h4);
		// Wide-address write code: command word would lead, no engine serves it
		pkt(8'h14, 8'hA5, 8'h94, 8'hA5, 32'h4);
		rd_chk(5'h1C, 32'h0);
		print_verdict();
	end
endmodule
`default_nettype wire
